// ==== src/hbs_status_regs.sv ====
// Status, identification and error registers of the host bridge function
`timescale 1ns/10ps
`include "hbs_defs.svh"
module hbs_status_regs
	import hbs_pkg::*;
#(
	// Arbitrary revision value
	parameter logic [7:0] REV_CODE = `HBS_REV_DEFAULT
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire hbs_cfg_req_s cfg_req,
	output logic [15:0]       cfg_rdata_q,
	output logic              cfg_ack_q,
	input  wire hbs_event_s   link_event,
	output logic              sys_err_msg,
	input  wire logic         sys_err_msg_ack
);
	logic [15:0] cmd_q;
	logic [15:0] error_command_q;
	logic        parity_err_seen;
	logic        sys_err_sent;
	logic        got_master_abort;
	logic        got_target_abort;
	logic        es_mabort_q;
	logic        es_tabort_q;
	logic [15:0] bridge_status;
	logic [15:0] error_status;
	logic [15:0] rdata_d;
	logic        msg_trigger;
	logic        msg_fired;
	hbs_msg_e    msg_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:1] == off[7:1]);
	endfunction

	function automatic logic [15:0] lanes(input logic [1:0] be);
		lanes = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	logic        wr_cmd;
	logic        wr_error_command;
	logic        wr_sts;
	logic        wr_ests;
	logic [15:0] wbits;
	assign wr_cmd    = cfg_req.wr && hit(cfg_req.addr, `HBS_OFF_CMD);
	assign wr_error_command = cfg_req.wr && hit(cfg_req.addr, `HBS_OFF_ERROR_COMMAND);
	assign wr_sts    = cfg_req.wr && hit(cfg_req.addr, `HBS_OFF_STATUS);
	assign wr_ests   = cfg_req.wr && hit(cfg_req.addr, `HBS_OFF_ERROR_STATUS);
	assign wbits     = cfg_req.wdata & lanes(cfg_req.be);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_q <= `HBS_CMD_RESET;
		end else if (wr_cmd) begin
			cmd_q <= (cmd_q & ~(`HBS_CMD_WMASK & lanes(cfg_req.be)))
				| (wbits & `HBS_CMD_WMASK);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			error_command_q <= 16'h0000;
		end else if (wr_error_command) begin
			error_command_q <= (error_command_q & ~(`HBS_ERROR_COMMAND_WMASK & lanes(cfg_req.be)))
				| (wbits & `HBS_ERROR_COMMAND_WMASK);
		end
	end

	// parity error messaged only when enabled
	assign msg_trigger = cmd_q[`HBS_CMD_SYS_ERR_ENABLE] && (
		(link_event.parity_err && cmd_q[`HBS_CMD_PARITY_ERR_ENABLE]) ||
		(link_event.master_abort && error_command_q[`HBS_EC_MABORT]) ||
		(link_event.target_abort && error_command_q[`HBS_EC_TABORT]));

	// Message request holds until the link takes it; extra events merge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			msg_q <= HBS_MSG_IDLE;
		end else begin
			case (msg_q)
				HBS_MSG_IDLE: begin
					if (msg_trigger) begin
						msg_q <= HBS_MSG_SEND;
					end
				end
				HBS_MSG_SEND: begin
					// A new event in the accepting cycle starts a fresh message
					if (sys_err_msg_ack && !msg_trigger) begin
						msg_q <= HBS_MSG_IDLE;
					end
				end
				default: begin
					msg_q <= HBS_MSG_IDLE;
				end
			endcase
		end
	end
	assign sys_err_msg = (msg_q == HBS_MSG_SEND);
	assign msg_fired   = sys_err_msg && sys_err_msg_ack;

	hbs_w1c_flag u_parity (
		.clk    (clk),
		.reset  (reset),
		.set    (link_event.parity_err),
		.clr    (wr_sts && wbits[`HBS_ST_PARITY]),
		.flag_q (parity_err_seen)
	);
	// flag set when message goes out
	hbs_w1c_flag u_syserr (
		.clk    (clk),
		.reset  (reset),
		.set    (msg_fired),
		.clr    (wr_sts && wbits[`HBS_ST_SYSERR]),
		.flag_q (sys_err_sent)
	);
	hbs_w1c_flag u_mabort (
		.clk    (clk),
		.reset  (reset),
		.set    (link_event.master_abort),
		.clr    (wr_sts && wbits[`HBS_ST_MABORT]),
		.flag_q (got_master_abort)
	);
	hbs_w1c_flag u_tabort (
		.clk    (clk),
		.reset  (reset),
		.set    (link_event.target_abort),
		.clr    (wr_sts && wbits[`HBS_ST_TABORT]),
		.flag_q (got_target_abort)
	);

	hbs_w1c_flag u_es_mabort (
		.clk    (clk),
		.reset  (reset),
		.set    (link_event.master_abort && error_command_q[`HBS_EC_MABORT]),
		.clr    (wr_ests && wbits[`HBS_EC_MABORT]),
		.flag_q (es_mabort_q)
	);
	hbs_w1c_flag u_es_tabort (
		.clk    (clk),
		.reset  (reset),
		.set    (link_event.target_abort && error_command_q[`HBS_EC_TABORT]),
		.clr    (wr_ests && wbits[`HBS_EC_TABORT]),
		.flag_q (es_tabort_q)
	);

	// Status word; hardwired and reserved bits are constants, so writes miss them
	always_comb begin
		bridge_status = 16'h0000;
		bridge_status[`HBS_ST_PARITY] = parity_err_seen;
		bridge_status[`HBS_ST_SYSERR] = sys_err_sent;
		bridge_status[`HBS_ST_MABORT] = got_master_abort;
		bridge_status[`HBS_ST_TABORT] = got_target_abort;
		bridge_status[`HBS_ST_SENT_TA] = 1'b0;
		bridge_status[10:9] = 2'b00;
		bridge_status[8] = 1'b0;
		bridge_status[`HBS_ST_B2B] = 1'b1;
		bridge_status[`HBS_ST_CAPLIST] = 1'b1;
		bridge_status[6:5] = 2'b00;
		bridge_status[3:0] = 4'h0;
		error_status = 16'h0000;
		error_status[`HBS_EC_MABORT] = es_mabort_q;
		error_status[`HBS_EC_TABORT] = es_tabort_q;
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rdata_d = 16'h0000;
		if (hit(cfg_req.addr, `HBS_OFF_CMD)) begin
			rdata_d = cmd_q;
		end else if (hit(cfg_req.addr, `HBS_OFF_STATUS)) begin
			rdata_d = bridge_status;
		end else if (hit(cfg_req.addr, `HBS_OFF_REV)) begin
			rdata_d = {8'h00, REV_CODE};
		end else if (hit(cfg_req.addr, `HBS_OFF_BRIDGE_SUBCLASS)) begin
			rdata_d = {8'h00, `HBS_BRIDGE_SUBCLASS_VALUE};
		end else if (hit(cfg_req.addr, `HBS_OFF_CAP_POINTER)) begin
			rdata_d = {8'h00, `HBS_CAP_POINTER_DEF};
		end else if (hit(cfg_req.addr, `HBS_OFF_ERROR_COMMAND)) begin
			rdata_d = error_command_q;
		end else if (hit(cfg_req.addr, `HBS_OFF_ERROR_STATUS)) begin
			rdata_d = error_status;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_rdata_q <= 16'h0000;
			cfg_ack_q   <= 1'b0;
		end else begin
			cfg_ack_q <= cfg_req.rd || cfg_req.wr;
			if (cfg_req.rd) begin
				cfg_rdata_q <= rdata_d;
			end
		end
	end

	sequence parity_hit_s;
		link_event.parity_err && cmd_q[`HBS_CMD_SYS_ERR_ENABLE] && cmd_q[`HBS_CMD_PARITY_ERR_ENABLE];
	endsequence
	sequence mabort_hit_s;
		link_event.master_abort && cmd_q[`HBS_CMD_SYS_ERR_ENABLE] && error_command_q[`HBS_EC_MABORT];
	endsequence
	sequence tabort_hit_s;
		link_event.target_abort && cmd_q[`HBS_CMD_SYS_ERR_ENABLE] && error_command_q[`HBS_EC_TABORT];
	endsequence
	sequence msg_out_s;
		sys_err_msg ##0 sys_err_msg_ack;
	endsequence
	sequence msg_wait_s;
		sys_err_msg ##0 !sys_err_msg_ack;
	endsequence

	parity_flag_a: assert property (@(posedge clk) disable iff (reset)
		link_event.parity_err |=> bridge_status[15]) else $error("parity flag missing");
	parity_clear_a: assert property (@(posedge clk) disable iff (reset)
		(wr_sts && wbits[`HBS_ST_PARITY] && !link_event.parity_err) |=> !parity_err_seen)
		else $error("parity flag not cleared");
	parity_quiet_a: assert property (@(posedge clk) disable iff (reset)
		(!parity_err_seen && !link_event.parity_err) |=> !parity_err_seen)
		else $error("parity flag set without error");
	syserr_flag_a: assert property (@(posedge clk) disable iff (reset)
		msg_out_s |=> bridge_status[14]) else $error("sys err flag missing");
	syserr_quiet_a: assert property (@(posedge clk) disable iff (reset)
		(!sys_err_sent && !msg_fired) |=> !sys_err_sent) else $error("sys err flag set early");
	msg_hold_a: assert property (@(posedge clk) disable iff (reset)
		msg_wait_s |=> sys_err_msg) else $error("message dropped before accept");
	error_status_set_a: assert property (@(posedge clk) disable iff (reset)
		(link_event.master_abort && error_command_q[1]) |=> error_status[1])
		else $error("error status missing");
	mabort_msg_a: assert property (@(posedge clk) disable iff (reset)
		mabort_hit_s |=> sys_err_msg) else $error("master abort message missing");
	tabort_msg_a: assert property (@(posedge clk) disable iff (reset)
		tabort_hit_s |=> sys_err_msg) else $error("target abort message missing");
	cmd_fixed_a: assert property (@(posedge clk) disable iff (reset)
		(cmd_q & ~`HBS_CMD_WMASK) == `HBS_CMD_RESET) else $error("command fixed bits moved");
	error_command_fixed_a: assert property (@(posedge clk) disable iff (reset)
		(error_command_q & ~`HBS_ERROR_COMMAND_WMASK) == 16'h0000) else $error("error command bits moved");
	cfg_ack_a: assert property (@(posedge clk) disable iff (reset)
		(cfg_req.rd || cfg_req.wr) |=> cfg_ack_q) else $error("access not acknowledged");
	rdata_hold_a: assert property (@(posedge clk) disable iff (reset)
		!cfg_req.rd |=> $stable(cfg_rdata_q)) else $error("read data changed without read");
	mabort_flag_a: assert property (@(posedge clk) disable iff (reset)
		link_event.master_abort |=> bridge_status[13]) else $error("master abort lost");
	mabort_clear_a: assert property (@(posedge clk) disable iff (reset)
		(wr_sts && wbits[`HBS_ST_MABORT] && !link_event.master_abort) |=> !got_master_abort)
		else $error("master abort not cleared");
	tabort_flag_a: assert property (@(posedge clk) disable iff (reset)
		link_event.target_abort |=> bridge_status[12]) else $error("target abort lost");
	tabort_clear_a: assert property (@(posedge clk) disable iff (reset)
		(wr_sts && wbits[`HBS_ST_TABORT] && !link_event.target_abort) |=> !got_target_abort)
		else $error("target abort not cleared");
	hard_bits_a: assert property (@(posedge clk) disable iff (reset)
		bridge_status[11:7] == 5'b00001) else $error("hardwired bits wrong");
	sel_timing_a: assert property (@(posedge clk) disable iff (reset)
		cfg_req.rd && hit(cfg_req.addr, 8'h06) |=> cfg_rdata_q[10:9] == 2'b00)
		else $error("select timing nonzero");
	cap_list_a: assert property (@(posedge clk) disable iff (reset)
		cfg_req.rd && hit(cfg_req.addr, 8'h06) |=> cfg_rdata_q[4] && cfg_rdata_q[7])
		else $error("capability bit wrong");
	rev_const_a: assert property (@(posedge clk) disable iff (reset)
		cfg_req.rd && hit(cfg_req.addr, 8'h08) |=> cfg_rdata_q == {8'h00, REV_CODE})
		else $error("revision changed");
	bridge_subclass_zero_a: assert property (@(posedge clk) disable iff (reset)
		cfg_req.rd && hit(cfg_req.addr, 8'h0A) |=> cfg_rdata_q == 16'h0000)
		else $error("sub-class nonzero");
	serr_gate_a: assert property (@(posedge clk) disable iff (reset)
		!sys_err_msg && !cmd_q[8] |=> !sys_err_msg) else $error("message while disabled");
	parity_msg_a: assert property (@(posedge clk) disable iff (reset)
		parity_hit_s |=> sys_err_msg) else $error("parity message missing");
	parity_off_a: assert property (@(posedge clk) disable iff (reset)
		(!sys_err_msg && link_event.parity_err && !cmd_q[`HBS_CMD_PARITY_ERR_ENABLE]
		&& !link_event.master_abort && !link_event.target_abort) |=> !sys_err_msg)
		else $error("parity message while disabled");
	reserved_a: assert property (@(posedge clk) disable iff (reset)
		bridge_status[6:5] == 2'b00 && bridge_status[3:0] == 4'h0)
		else $error("reserved bits set");
endmodule

// ==== src/hbs_defs.svh ====
// Offsets, field positions, reset values and constants of the status block
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH
`define HBS_OFF_CMD      8'h04
`define HBS_OFF_STATUS   8'h06
`define HBS_OFF_REV      8'h08
`define HBS_OFF_BRIDGE_SUBCLASS     8'h0A
`define HBS_OFF_CAP_POINTER   8'h34
`define HBS_OFF_ERROR_COMMAND   8'h90
`define HBS_OFF_ERROR_STATUS   8'h92
`define HBS_ST_PARITY    15
`define HBS_ST_SYSERR    14
`define HBS_ST_MABORT    13
`define HBS_ST_TABORT    12
`define HBS_ST_SENT_TA   11
`define HBS_ST_B2B       7
`define HBS_ST_CAPLIST   4
`define HBS_CMD_SYS_ERR_ENABLE    8
`define HBS_CMD_PARITY_ERR_ENABLE    6
`define HBS_EC_MABORT    1
`define HBS_EC_TABORT    0
`define HBS_CMD_RESET    16'h0006
`define HBS_CMD_WMASK    16'h0140
`define HBS_ERROR_COMMAND_WMASK 16'h0003
`define HBS_REV_DEFAULT  8'h5A
`define HBS_BRIDGE_SUBCLASS_VALUE   8'h00
`define HBS_CAP_POINTER_DEF   8'hA0
`endif

// ==== src/hbs_pkg.sv ====
// Types shared by the status block
package hbs_pkg;
	typedef struct packed {
		logic       parity_err;
		logic       master_abort;
		logic       target_abort;
	} hbs_event_s;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [1:0] be;
	} hbs_cfg_req_s;
	typedef enum logic [1:0] {
		HBS_MSG_IDLE = 2'b00,
		HBS_MSG_SEND = 2'b01
	} hbs_msg_e;
endpackage

// ==== src/hbs_w1c_flag.sv ====
// One sticky flag, set by hardware, cleared by writing one
`timescale 1ns/10ps
module hbs_w1c_flag
	import hbs_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);
	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clr) begin
			flag_q <= 1'b0;
		end
	end
	set_wins_a: assert property (@(posedge clk) disable iff (reset)
		set |=> flag_q) else $error("flag not set");
	clr_works_a: assert property (@(posedge clk) disable iff (reset)
		(clr && !set) |=> !flag_q) else $error("flag not cleared");
endmodule

// ==== test/hbs_status_regs_test.sv ====
// Self-checking bench for the host bridge status and identification registers
`timescale 1ns/10ps
`include "hbs_defs.svh"
module hbs_status_regs_test
	import hbs_pkg::*;
;
	// Arbitrary revision value for this run
	localparam logic [7:0] REV = 8'h3C;
	logic         clk;
	logic         reset;
	hbs_cfg_req_s cfg_req;
	logic [15:0]  cfg_rdata_q;
	logic         cfg_ack_q;
	hbs_event_s   link_event;
	logic         sys_err_msg;
	logic         sys_err_msg_ack;
	int           n_fail;
	int           checks;

	hbs_status_regs #(.REV_CODE(REV)) hbs_status_regs_inst (
		.clk             (clk),
		.reset           (reset),
		.cfg_req         (cfg_req),
		.cfg_rdata_q     (cfg_rdata_q),
		.cfg_ack_q       (cfg_ack_q),
		.link_event      (link_event),
		.sys_err_msg     (sys_err_msg),
		.sys_err_msg_ack (sys_err_msg_ack)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Requests rise just after an edge and are taken at the next one
	task automatic cfg_write(input logic [7:0] addr, input logic [15:0] data);
		@(posedge clk);
		#1;
		cfg_req.wr = 1'b1;
		cfg_req.addr = addr;
		cfg_req.wdata = data;
		cfg_req.be = 2'h3;
		@(posedge clk);
		#1;
		cfg_req.wr = 1'b0;
		check("write ack", 16'h0001, {15'h0000, cfg_ack_q});
	endtask

	task automatic cfg_read(input logic [7:0] addr, input logic [15:0] exp, input string what);
		@(posedge clk);
		#1;
		cfg_req.rd = 1'b1;
		cfg_req.addr = addr;
		@(posedge clk);
		#1;
		cfg_req.rd = 1'b0;
		check("read ack", 16'h0001, {15'h0000, cfg_ack_q});
		check(what, exp, cfg_rdata_q);
	endtask

	task automatic check_msg(input logic exp);
		check("sys_err_msg", {15'h0000, exp}, {15'h0000, sys_err_msg});
	endtask

	// Events are one-cycle pulses; flags are visible after the taking edge
	task automatic pulse_event(input hbs_event_s ev);
		@(posedge clk);
		#1;
		link_event = ev;
		@(posedge clk);
		#1;
		link_event = 3'h0;
	endtask

	task automatic accept_msg();
		@(posedge clk);
		#1;
		sys_err_msg_ack = 1'b1;
		@(posedge clk);
		#1;
		sys_err_msg_ack = 1'b0;
		check_msg(1'b0);
	endtask

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Whole run is about a hundred and ten cycles; this leaves wide margin
	initial begin
		#20000;
		n_fail++;
		complete_run();
	end

	initial begin
		n_fail = 0;
		checks = 0;
		reset = 1'b1;
		cfg_req = '0;
		link_event = 3'h0;
		sys_err_msg_ack = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		cfg_read(`HBS_OFF_STATUS, 16'h0090, "status reset"); // fixed bits
		cfg_read(`HBS_OFF_REV, {8'h00, REV}, "revision"); // revision value
		cfg_read(`HBS_OFF_BRIDGE_SUBCLASS, 16'h0000, "subclass"); // subclass code
		cfg_read(`HBS_OFF_CAP_POINTER, {8'h00, `HBS_CAP_POINTER_DEF}, "cap pointer"); // pointer
		cfg_read(`HBS_OFF_CMD, `HBS_CMD_RESET, "command reset"); // enables off
		cfg_read(8'h40, 16'h0000, "unmapped"); // reserved space reads zero
		cfg_write(`HBS_OFF_STATUS, 16'h0F7F); // write to fixed bits
		cfg_read(`HBS_OFF_STATUS, 16'h0090, "status fixed"); // fixed bits kept
		cfg_write(`HBS_OFF_REV, 16'hFFFF); // write ignored
		cfg_read(`HBS_OFF_REV, {8'h00, REV}, "revision kept"); // value kept
		cfg_write(`HBS_OFF_BRIDGE_SUBCLASS, 16'hFFFF); // write ignored
		cfg_read(`HBS_OFF_BRIDGE_SUBCLASS, 16'h0000, "subclass kept"); // value kept
		// Global enable off: flag set, no message
		pulse_event(3'h4); // parity error
		check_msg(1'b0); // global enable off
		cfg_read(`HBS_OFF_STATUS, 16'h8090, "parity flag"); // flag set
		cfg_write(`HBS_OFF_STATUS, 16'h8000); // write one clears
		cfg_read(`HBS_OFF_STATUS, 16'h0090, "parity cleared"); // flag cleared
		cfg_write(`HBS_OFF_CMD, 16'h0140); // both enables on
		pulse_event(3'h4); // parity error
		check_msg(1'b1); // message raised
		accept_msg(); // message accepted
		cfg_read(`HBS_OFF_STATUS, 16'hC090, "message flag"); // sent flag
		cfg_write(`HBS_OFF_STATUS, 16'hC000); // write one clears
		cfg_write(`HBS_OFF_CMD, 16'h0100); // parity enable off
		pulse_event(3'h4); // parity error
		check_msg(1'b0); // no message
		cfg_read(`HBS_OFF_STATUS, 16'h8090, "parity only"); // no message flag
		cfg_write(`HBS_OFF_STATUS, 16'h8000); // write one clears
		cfg_write(`HBS_OFF_ERROR_COMMAND, 16'h0003); // abort enables
		pulse_event(3'h2); // master abort
		check_msg(1'b1); // enabled condition
		cfg_read(`HBS_OFF_ERROR_STATUS, 16'h0002, "error_status master"); // error flag
		accept_msg(); // message accepted
		cfg_read(`HBS_OFF_STATUS, 16'h6090, "master abort"); // flag set
		pulse_event(3'h1); // target abort
		check_msg(1'b1); // enabled condition
		accept_msg(); // message accepted
		cfg_read(`HBS_OFF_STATUS, 16'h7090, "target abort"); // flag set
		cfg_read(`HBS_OFF_ERROR_STATUS, 16'h0003, "error_status both"); // error flags
		cfg_write(`HBS_OFF_STATUS, 16'h3000); // write one clears
		cfg_write(`HBS_OFF_ERROR_STATUS, 16'h0003); // write one clears
		cfg_read(`HBS_OFF_STATUS, 16'h4090, "aborts cleared"); // cleared
		cfg_write(`HBS_OFF_STATUS, 16'h4000); // write one clears
		cfg_read(`HBS_OFF_STATUS, 16'h0090, "all cleared"); // cleared
		cfg_read(`HBS_OFF_ERROR_STATUS, 16'h0000, "error_status cleared"); // cleared
		cfg_read(`HBS_OFF_ERROR_COMMAND, 16'h0003, "error command"); // enables held
		cfg_write(`HBS_OFF_CMD, 16'h0000); // global enable off
		pulse_event(3'h2); // master abort
		check_msg(1'b0); // no message
		cfg_read(`HBS_OFF_ERROR_STATUS, 16'h0002, "error_status no message"); // flag still set
		// Event and write-one clear in one cycle: the event wins
		fork
			pulse_event(3'h4); // parity error
			cfg_write(`HBS_OFF_STATUS, 16'hA000); // same-cycle clear
		join
		cfg_read(`HBS_OFF_STATUS, 16'h8090, "set beats clear"); // set wins
		// Mid-run reset returns every flag and enable to its default
		@(posedge clk);
		#1;
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		cfg_read(`HBS_OFF_STATUS, 16'h0090, "status after reset"); // flags dropped
		cfg_read(`HBS_OFF_ERROR_STATUS, 16'h0000, "error_status after reset"); // flags dropped
		cfg_read(`HBS_OFF_ERROR_COMMAND, 16'h0000, "error_command after reset"); // enables off
		cfg_read(`HBS_OFF_CMD, `HBS_CMD_RESET, "command after reset"); // enables off
		complete_run();
	end
endmodule
